/* File: io_bus_params.svh */
// offsets, field positions, reset values and timing counts of the port and bus unit
`ifndef IO_BUS_PARAMS_SVH
`define IO_BUS_PARAMS_SVH

// external address spaces, one for code and one for data
`define EXT_ADDR_W 16

// oscillator periods per machine cycle and per bus slot
`define CLKS_PER_MC 12
`define SLOT_LAST 3'h5
`define ADDR_PHASES 3'h2
`define STROBE_PHASE 3'h3

// reset pin must stay high this many machine cycles
`define RST_HOLD_MC 2

// on-chip code memory limits for the two variants
`define ROM_SMALL_LIMIT 16'h0FFF
`define ROM_LARGE_LIMIT 16'h1FFF
`define ROM_SMALL_AW 12
`define ROM_LARGE_AW 13

// on-chip read/write data memory
`define RAM_DEPTH 128
`define RAM_AW 7

// reset values of pins
`define PORT_RST 8'hFF
`define ALE_RST 1'b1
`define STROBE_RST 1'b1

// fourth port alternate function bit positions
`define P3_RXD 0
`define P3_TXD 1
`define P3_EVT0 2
`define P3_EVT1 3
`define P3_CNT0 4
`define P3_CNT1 5
`define P3_WR 6
`define P3_RD 7

// third port mode pattern and address bits while held in reset
`define P2_MODE_HI 7
`define P2_MODE_LO 5
`define MODE_BURN_PULSE_INPUT_PAT 3'h4
`define MODE_VERIFY_PAT 3'h0
`define P2_ADDR_HI 4

`endif

/* File: io_bus_pkg.sv */
// types shared by the port and external bus unit
package io_bus_pkg;

	// bus slot kinds, gray coded along idle, fetch, data first, data second
	typedef enum logic [1:0] {
		SLOT_IDLE = 2'b00,
		SLOT_FETCH = 2'b01,
		SLOT_DATA_A = 2'b11,
		SLOT_DATA_B = 2'b10
	} slot_e;

	// pin modes of the device
	typedef enum logic [1:0] {
		MODE_RUN = 2'b00,
		MODE_HOLD = 2'b01,
		MODE_VERIFY = 2'b11,
		MODE_BURN_PULSE_INPUT = 2'b10
	} mode_e;

	// one byte per port, first port in the low byte
	typedef struct packed {
		logic [7:0] p3;
		logic [7:0] p2;
		logic [7:0] p1;
		logic [7:0] p0;
	} port_latch_s;

	// request from the core: code fetch or data move
	typedef struct packed {
		logic fetch;
		logic [15:0] pc;
		logic data;
		logic wide;
		logic write;
		logic [15:0] daddr;
		logic [7:0] wdata;
	} core_req_s;

endpackage

/* File: sync_byte_mem.sv */
// single-port byte memory with registered read data
`timescale 1ns/100ps
module sync_byte_mem #(
	parameter int DEPTH = 128,
	parameter int AW = 7
) (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// access port
	input wire logic we,
	input wire logic [AW-1:0] addr,
	input wire logic [7:0] wdata,
	output logic [7:0] rdata_ff
);

	logic [7:0] mem_q [DEPTH];

	// array has no reset, contents are undefined until written
	always_ff @(posedge clk) begin
		if (we) begin
			mem_q[addr] <= wdata;
		end
	end

	// read data always from a flop, one clock after the address
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata_ff <= 8'h00;
		end else begin
			rdata_ff <= mem_q[addr];
		end
	end

endmodule

/* File: io_ports_and_external_bus.sv */
// four i/o ports, multiplexed external bus sequencer, reset and program pins
`timescale 1ns/100ps
`include "io_bus_params.svh"
module io_ports_and_external_bus
	import io_bus_pkg::*;
#(
	parameter bit LARGE_VARIANT = 1'b0,
	parameter int ROM_AW = LARGE_VARIANT ? `ROM_LARGE_AW : `ROM_SMALL_AW
) (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// core requests and port latches
	input wire core_req_s req,
	input wire port_latch_s latch,
	input wire logic txd_bit,
	// core answers
	output logic req_taken_ff,
	output logic [7:0] code_byte_ff,
	output logic code_valid_ff,
	output logic [7:0] data_rdata_ff,
	output logic data_valid_ff,
	output port_latch_s pin_in_ff,
	output logic core_reset_ff,
	// on-chip data memory port
	input wire logic ram_we,
	input wire logic [`RAM_AW-1:0] ram_addr,
	input wire logic [7:0] ram_wdata,
	output logic [7:0] ram_rdata_ff,
	// port pins
	input wire port_latch_s port_pin_in,
	output port_latch_s port_out_ff,
	output port_latch_s port_oe_n_ff,
	// control pins
	input wire logic reset_standby_pin,
	input wire logic external_fetch_select,
	input wire logic addr_latch_burn_pin_in,
	output logic addr_latch_burn_pin_out_ff,
	output logic addr_latch_burn_pin_oe_n_ff,
	output logic program_fetch_strobe_n_ff,
	output logic program_fetch_strobe_oe_n_ff
);

	localparam logic [15:0] ROM_LIMIT = LARGE_VARIANT ? `ROM_LARGE_LIMIT : `ROM_SMALL_LIMIT;
	localparam logic [4:0] RST_HOLD = 5'(`RST_HOLD_MC * `CLKS_PER_MC);
	localparam int ROM_DEPTH = 1 << ROM_AW;

	logic [34:0] sync1_ff;
	logic [2:0] ctl_s_ff;
	logic burn_pulse_input;
	logic ea_s;
	logic rst_s;
	logic [4:0] rst_cnt_ff;
	mode_e mode_ff;
	logic [2:0] phase_ff;
	slot_e state_ff;
	logic slot_end;
	logic addr_phase;
	logic take;
	logic [15:0] pc_ff;
	logic ext_ff;
	logic [15:0] daddr_ff;
	logic [7:0] wdata_ff;
	logic wide_ff;
	logic write_ff;
	logic cap_code_ff;
	logic cap_ext_ff;
	logic cap_data_ff;
	logic [7:0] int_hold_ff;
	logic burn_prev_ff;
	logic burn_fall;
	logic [12:0] pin_addr;
	logic [ROM_AW-1:0] rom_addr;
	logic [7:0] rom_rdata;
	logic bus_fetch;
	logic bus_data;
	logic strobe_on;
	port_latch_s nxt_port_out;
	port_latch_s nxt_port_oe_n;
	logic nxt_ale_out;
	logic nxt_ale_oe_n;
	logic nxt_program_fetch_strobe_n;
	logic nxt_program_fetch_strobe_oe_n;

	// first stage of every pin input; read only by the second stage
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			// idle pin levels, so no false program edge or mode strap after reset
			sync1_ff <= {1'b1, 1'b0, 1'b0, {4{`PORT_RST}}};
		end else begin
			sync1_ff <= {addr_latch_burn_pin_in, external_fetch_select, reset_standby_pin,
				port_pin_in};
		end
	end

	// second stage, the only copy that logic reads
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pin_in_ff <= {4{`PORT_RST}};
			ctl_s_ff <= 3'h4;
		end else begin
			pin_in_ff <= port_latch_s'(sync1_ff[31:0]);
			ctl_s_ff <= sync1_ff[34:32];
		end
	end

	assign burn_pulse_input = ctl_s_ff[2];
	assign ea_s = ctl_s_ff[1];
	assign rst_s = ctl_s_ff[0];

	// reset pin qualified by a hold count of whole machine cycles
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_cnt_ff <= 5'h00;
		end else if (!rst_s) begin
			rst_cnt_ff <= 5'h00;
		end else if (rst_cnt_ff != RST_HOLD) begin
			rst_cnt_ff <= rst_cnt_ff + 5'h01;
		end
	end

	// core stays in reset while the pin is high past the hold count
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			core_reset_ff <= 1'b1;
		end else begin
			core_reset_ff <= rst_s && (rst_cnt_ff == RST_HOLD);
		end
	end

	// mode straps read from the third port only while reset holds
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			mode_ff <= MODE_HOLD;
		end else if (!core_reset_ff) begin
			mode_ff <= MODE_RUN;
		end else begin
			case (pin_in_ff.p2[`P2_MODE_HI:`P2_MODE_LO])
				`MODE_BURN_PULSE_INPUT_PAT: mode_ff <= MODE_BURN_PULSE_INPUT;
				`MODE_VERIFY_PAT: mode_ff <= MODE_VERIFY;
				default: mode_ff <= MODE_HOLD;
			endcase
		end
	end

	assign slot_end = (phase_ff == `SLOT_LAST);
	assign addr_phase = (phase_ff < `ADDR_PHASES);
	assign take = !core_reset_ff && slot_end && (state_ff != SLOT_DATA_A) && (req.data || req.fetch);

	// six oscillator periods per slot, two slots per machine cycle
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			phase_ff <= 3'h0;
		end else if (core_reset_ff || slot_end) begin
			phase_ff <= 3'h0;
		end else begin
			phase_ff <= phase_ff + 3'h1;
		end
	end

	// slot sequencer; a data access always spans two slots
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_ff <= SLOT_IDLE;
		end else if (core_reset_ff) begin
			state_ff <= SLOT_IDLE;
		end else if (slot_end) begin
			case (state_ff)
				SLOT_DATA_A: state_ff <= SLOT_DATA_B;
				default: begin
					if (req.data) begin
						state_ff <= SLOT_DATA_A;
					end else if (req.fetch) begin
						state_ff <= SLOT_FETCH;
					end else begin
						state_ff <= SLOT_IDLE;
					end
				end
			endcase
		end
	end

	// request fields held for the whole access
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pc_ff <= 16'h0000;
			ext_ff <= 1'b0;
			daddr_ff <= 16'h0000;
			wdata_ff <= 8'h00;
			wide_ff <= 1'b0;
			write_ff <= 1'b0;
		end else if (take) begin
			pc_ff <= req.pc;
			ext_ff <= !ea_s || (req.pc > ROM_LIMIT);
			daddr_ff <= req.daddr;
			wdata_ff <= req.wdata;
			wide_ff <= req.wide;
			write_ff <= req.write;
		end
	end

	// take pulse back to the core
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			req_taken_ff <= 1'b0;
		end else begin
			req_taken_ff <= take;
		end
	end

	// captures wait two clocks into the next slot to cover the input synchroniser
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cap_code_ff <= 1'b0;
			cap_ext_ff <= 1'b0;
			cap_data_ff <= 1'b0;
			int_hold_ff <= 8'h00;
		end else if (slot_end) begin
			cap_code_ff <= (state_ff == SLOT_FETCH) && !core_reset_ff;
			cap_ext_ff <= ext_ff;
			cap_data_ff <= (state_ff == SLOT_DATA_B) && !write_ff && !core_reset_ff;
			int_hold_ff <= rom_rdata;
		end else if (phase_ff == 3'h1) begin
			cap_code_ff <= 1'b0;
			cap_data_ff <= 1'b0;
		end
	end

	// code byte from the pins or from on-chip memory, one pulse each fetch
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			code_byte_ff <= 8'h00;
			code_valid_ff <= 1'b0;
		end else begin
			code_valid_ff <= cap_code_ff && (phase_ff == 3'h1);
			if (cap_code_ff && (phase_ff == 3'h1)) begin
				code_byte_ff <= cap_ext_ff ? pin_in_ff.p0 : int_hold_ff;
			end
		end
	end

	// external data read byte, one pulse each read
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			data_rdata_ff <= 8'h00;
			data_valid_ff <= 1'b0;
		end else begin
			data_valid_ff <= cap_data_ff && (phase_ff == 3'h1);
			if (cap_data_ff && (phase_ff == 3'h1)) begin
				data_rdata_ff <= pin_in_ff.p0;
			end
		end
	end

	// falling edge of the program pulse, taken from the synchronised copy
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			burn_prev_ff <= 1'b1;
		end else begin
			burn_prev_ff <= burn_pulse_input;
		end
	end

	assign burn_fall = burn_prev_ff && !burn_pulse_input && (mode_ff == MODE_BURN_PULSE_INPUT);
	assign pin_addr = {pin_in_ff.p2[`P2_ADDR_HI:0], pin_in_ff.p1};
	assign rom_addr = ((mode_ff == MODE_BURN_PULSE_INPUT) || (mode_ff == MODE_VERIFY)) ?
		pin_addr[ROM_AW-1:0] : pc_ff[ROM_AW-1:0];

	// on-chip code memory, written only by program pulses
	sync_byte_mem #(
		.DEPTH(ROM_DEPTH),
		.AW(ROM_AW)
	) u_code_mem (
		.clk(clk),
		.arst_n(arst_n),
		.we(burn_fall),
		.addr(rom_addr),
		.wdata(pin_in_ff.p0),
		.rdata_ff(rom_rdata)
	);

	// on-chip data memory for the core
	sync_byte_mem #(
		.DEPTH(`RAM_DEPTH),
		.AW(`RAM_AW)
	) u_data_mem (
		.clk(clk),
		.arst_n(arst_n),
		.we(ram_we),
		.addr(ram_addr),
		.wdata(ram_wdata),
		.rdata_ff(ram_rdata_ff)
	);

	assign bus_fetch = (state_ff == SLOT_FETCH) && ext_ff;
	assign bus_data = (state_ff == SLOT_DATA_A) || (state_ff == SLOT_DATA_B);
	assign strobe_on = ((state_ff == SLOT_DATA_A) && (phase_ff >= `STROBE_PHASE)) ||
		(state_ff == SLOT_DATA_B);

	// pin drive; oe_n low means driving, a released pin reads its pull-up
	always_comb begin
		nxt_port_out = latch;
		nxt_port_oe_n = latch;
		nxt_port_out.p3[`P3_TXD] = latch.p3[`P3_TXD] & txd_bit;
		nxt_port_out.p3[`P3_WR] = latch.p3[`P3_WR] & !(strobe_on && write_ff);
		nxt_port_out.p3[`P3_RD] = latch.p3[`P3_RD] & !(strobe_on && !write_ff);
		nxt_port_oe_n.p3 = nxt_port_out.p3;
		nxt_ale_out = `ALE_RST;
		nxt_ale_oe_n = 1'b0;
		nxt_program_fetch_strobe_n = `STROBE_RST;
		nxt_program_fetch_strobe_oe_n = 1'b0;
		case (mode_ff)
			MODE_RUN: begin
				if (bus_fetch) begin
					nxt_port_out.p0 = addr_phase ? pc_ff[7:0] : `PORT_RST;
					nxt_port_oe_n.p0 = addr_phase ? 8'h00 : `PORT_RST;
					nxt_port_out.p2 = pc_ff[15:8];
					nxt_port_oe_n.p2 = 8'h00;
				end else if (bus_data) begin
					if ((state_ff == SLOT_DATA_A) && addr_phase) begin
						nxt_port_out.p0 = daddr_ff[7:0];
						nxt_port_oe_n.p0 = 8'h00;
					end else if (write_ff) begin
						nxt_port_out.p0 = wdata_ff;
						nxt_port_oe_n.p0 = 8'h00;
					end else begin
						nxt_port_out.p0 = `PORT_RST;
						nxt_port_oe_n.p0 = `PORT_RST;
					end
					if (wide_ff) begin
						nxt_port_out.p2 = daddr_ff[15:8];
						nxt_port_oe_n.p2 = 8'h00;
					end // narrow moves keep the latch value
				end
				nxt_ale_out = addr_phase && (state_ff != SLOT_DATA_B);
				nxt_program_fetch_strobe_n = !(bus_fetch && (phase_ff >= `STROBE_PHASE));
			end
			MODE_VERIFY: begin
				nxt_port_out = {4{`PORT_RST}};
				nxt_port_oe_n = {4{`PORT_RST}};
				nxt_port_out.p0 = rom_rdata;
				nxt_port_oe_n.p0 = rom_rdata;
				nxt_ale_oe_n = 1'b1;
				nxt_program_fetch_strobe_oe_n = 1'b1;
			end
			MODE_BURN_PULSE_INPUT: begin
				nxt_port_out = {4{`PORT_RST}};
				nxt_port_oe_n = {4{`PORT_RST}};
				nxt_ale_oe_n = 1'b1;
				nxt_program_fetch_strobe_oe_n = 1'b1;
			end
			default: begin
				// held in reset: release ports so the mode straps can be read
				nxt_port_out = {4{`PORT_RST}};
				nxt_port_oe_n = {4{`PORT_RST}};
				nxt_program_fetch_strobe_oe_n = 1'b1;
			end
		endcase
	end

	// every pin comes from a flop, so pins lag the sequencer by one clock
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			port_out_ff <= {4{`PORT_RST}};
			port_oe_n_ff <= {4{`PORT_RST}};
			addr_latch_burn_pin_out_ff <= `ALE_RST;
			addr_latch_burn_pin_oe_n_ff <= 1'b0;
			program_fetch_strobe_n_ff <= `STROBE_RST;
			program_fetch_strobe_oe_n_ff <= 1'b1;
		end else begin
			port_out_ff <= nxt_port_out;
			port_oe_n_ff <= nxt_port_oe_n;
			addr_latch_burn_pin_out_ff <= nxt_ale_out;
			addr_latch_burn_pin_oe_n_ff <= nxt_ale_oe_n;
			program_fetch_strobe_n_ff <= nxt_program_fetch_strobe_n;
			program_fetch_strobe_oe_n_ff <= nxt_program_fetch_strobe_oe_n;
		end
	end

endmodule

/* File: io_bus_checker.sv */
// assertions on the port and bus pins of the port and bus unit
`timescale 1ns/100ps
`include "io_bus_params.svh"
module io_bus_checker
	import io_bus_pkg::*;
#(
	parameter bit LARGE_VARIANT = 1'b0
) (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// core side
	input wire core_req_s req,
	input wire port_latch_s latch,
	input wire logic req_taken_ff,
	input wire logic code_valid_ff,
	input wire logic data_valid_ff,
	input wire logic core_reset_ff,
	// pins
	input wire port_latch_s port_out_ff,
	input wire port_latch_s port_oe_n_ff,
	input wire logic reset_standby_pin,
	input wire logic external_fetch_select,
	input wire logic addr_latch_burn_pin_out_ff,
	input wire logic program_fetch_strobe_n_ff
);
	localparam logic [15:0] LIMIT = LARGE_VARIANT ? `ROM_LARGE_LIMIT : `ROM_SMALL_LIMIT;
	logic [5:0] hi_cnt_ff;
	logic fetch_t;
	logic data_t;
	logic ale;
	// cycles with the reset pin high, saturating so it never wraps
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			hi_cnt_ff <= '0;
		end else begin
			hi_cnt_ff <= !reset_standby_pin ? '0 : hi_cnt_ff + {5'h0, hi_cnt_ff != 6'h3F};
		end
	end
	// kind of the request just taken; the core holds it up to this cycle
	assign fetch_t = req_taken_ff && !req.data;
	assign data_t = req_taken_ff && req.data;
	assign ale = addr_latch_burn_pin_out_ff;
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	// pins are one clock behind the take pulse, and the core drops req at that clock
	a_fetch_addr_out: assert property (
		fetch_t && (!external_fetch_select || req.pc > LIMIT) |-> ##1 (ale
		&& port_out_ff.p0 == $past(req.pc[7:0]) && port_out_ff.p2 == $past(req.pc[15:8])
		&& port_oe_n_ff.p0 == 8'h00 && port_oe_n_ff.p2 == 8'h00))
		else $error("fetch address missing on the bus");
	a_data_addr_out: assert property (
		data_t |-> ##1 (port_out_ff.p0 == $past(req.daddr[7:0])
		&& port_out_ff.p2 == ($past(req.wide) ? $past(req.daddr[15:8]) : latch.p2)))
		else $error("data address wrong on the bus");
	a_code_valid_time: assert property (fetch_t |-> ##8 code_valid_ff)
		else $error("code byte not delivered in time");
	a_read_valid_time: assert property (data_t && !req.write |-> ##14 data_valid_ff)
		else $error("read byte not delivered in time");
	a_read_strobe_low: assert property (
		data_t && !req.write |-> ##4 (!(port_out_ff.p3[7] || port_oe_n_ff.p3[7]))[*8])
		else $error("read strobe not held low");
	a_strobe_skip_data: assert property (
		data_t |-> ##1 program_fetch_strobe_n_ff[*8] ##1 program_fetch_strobe_n_ff[*3])
		else $error("fetch strobe active during data access");
	a_ext_fetch_strobe: assert property (
		fetch_t && (!external_fetch_select || req.pc > LIMIT)
		|-> ##4 (!program_fetch_strobe_n_ff)[*3])
		else $error("fetch strobe missing for external fetch");
	a_int_fetch_quiet: assert property (
		fetch_t && external_fetch_select && req.pc <= LIMIT
		|-> ##1 program_fetch_strobe_n_ff[*8])
		else $error("fetch strobe active for on-chip fetch");
	a_latch_rate: assert property (disable iff (!arst_n || core_reset_ff)
		$rose(ale) |-> ale[*2] ##1 (!ale)[*4] ##[1:7] $rose(ale))
		else $error("latch pulse off its six clock rate");
	a_latch_skip: assert property (disable iff (!arst_n || core_reset_ff)
		data_t |-> ##7 (!ale)[*6] ##1 ale)
		else $error("latch pulse not skipped once");
	a_reset_length: assert property ($rose(core_reset_ff) |-> hi_cnt_ff >= 6'h18)
		else $error("core reset after too short a pin pulse");
	// pins settle two clocks into reset; first port may show verify bytes
	a_reset_release: assert property (
		core_reset_ff && $past(core_reset_ff) && $past(core_reset_ff, 2)
		|-> port_oe_n_ff[31:8] == 24'hFFFFFF)
		else $error("port driven during reset");
endmodule

bind io_ports_and_external_bus io_bus_checker #(.LARGE_VARIANT(LARGE_VARIANT)) chk (
	.clk, .arst_n, .req, .latch, .req_taken_ff, .code_valid_ff, .data_valid_ff,
	.core_reset_ff, .port_out_ff, .port_oe_n_ff, .reset_standby_pin,
	.external_fetch_select, .addr_latch_burn_pin_out_ff, .program_fetch_strobe_n_ff);

/* File: ext_mem_model.sv */
// external code and data memories with their address latch
`timescale 1ns/100ps
module ext_mem_model
	import io_bus_pkg::*;
(
	// board clock
	input wire logic clk,
	// resolved pins
	input wire logic ale,
	input wire logic fetch_n,
	input wire port_latch_s pin,
	// drive back onto the first port
	output logic [7:0] p0_drv,
	output logic p0_en
);
	logic [15:0] addr_ff;
	logic [7:0] xram [256];
	// code contents follow a fixed pattern of the address
	function automatic logic [7:0] code_at(input logic [15:0] a);
		return a[7:0] ^ a[15:8] ^ 8'hA5;
	endfunction
	// address loaded while the latch pulse is high; writes taken while strobe low
	always @(posedge clk) begin
		if (ale) begin
			addr_ff <= {pin.p2, pin.p0};
		end
		if (!pin.p3[6]) begin
			xram[addr_ff[7:0]] <= pin.p0;
		end
	end
	// drives only under a strobe, so the bus falls back to its pull-ups
	assign p0_en = !fetch_n || !pin.p3[7];
	assign p0_drv = !fetch_n ? code_at(addr_ff) : xram[addr_ff[7:0]];
endmodule

/* File: io_ports_and_external_bus_bench.sv */
// self-checking bench for the port and external bus unit
`timescale 1ns/100ps
module io_ports_and_external_bus_bench import io_bus_pkg::*; ();
	typedef struct packed {logic d; logic w; logic wr; logic [15:0] a; logic [7:0] v;} row_s;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	core_req_s req = '0;
	port_latch_s latch = {8'hFF, 8'h5A, 8'hFF, 8'hFF};
	port_latch_s ext_drv = '1;
	logic txd_bit = 1'b1;
	logic rst_pin = 1'b0;
	logic ext_sel = 1'b0;
	logic burn_pulse_input_n = 1'b1;
	logic ram_we = 1'b0;
	logic [6:0] ram_addr = '0;
	logic [7:0] ram_wdata = '0;
	logic req_taken_ff, code_valid_ff, data_valid_ff, core_reset_ff, m_en;
	logic [7:0] code_byte_ff, data_rdata_ff, ram_rdata_ff, m_drv;
	port_latch_s pin_in_ff, port_out_ff, port_oe_n_ff, pins;
	logic ale_out, ale_oe_n, strobe_n, strobe_oe_n, ale_pin, fetch_pin;
	int n_fail = 0;
	int n_compared = 0;
	int n_strobe = 0;
	// fetches, writes and reads with data winning over a held fetch
	row_s rows [6] = '{'{1'b0, 1'b0, 1'b0, 16'h0100, 8'h00}, '{1'b0, 1'b0, 1'b0, 16'hFFFF, 8'h00},
		'{1'b1, 1'b1, 1'b1, 16'h8042, 8'h3C}, '{1'b1, 1'b1, 1'b0, 16'h8042, 8'h3C},
		'{1'b1, 1'b0, 1'b1, 16'h0077, 8'hC3}, '{1'b1, 1'b0, 1'b0, 16'h0077, 8'hC3}};

	always #12.5 clk = ~clk;
	// wired pins: released lines read high through pull-ups
	assign pins = (port_out_ff | port_oe_n_ff) & ext_drv & {24'hFFFFFF, m_en ? m_drv : 8'hFF};
	assign ale_pin = (ale_out | ale_oe_n) & burn_pulse_input_n;
	assign fetch_pin = strobe_n | strobe_oe_n;
	// strobe activity, to tell on-chip from external fetches
	always @(posedge clk) if (fetch_pin === 1'b0) n_strobe++;

	io_ports_and_external_bus DUT (.clk(clk), .arst_n(arst_n), .req(req), .latch(latch),
		.txd_bit(txd_bit), .req_taken_ff(req_taken_ff), .code_byte_ff(code_byte_ff),
		.code_valid_ff(code_valid_ff), .data_rdata_ff(data_rdata_ff),
		.data_valid_ff(data_valid_ff), .pin_in_ff(pin_in_ff), .core_reset_ff(core_reset_ff),
		.ram_we(ram_we), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
		.ram_rdata_ff(ram_rdata_ff), .port_pin_in(pins), .port_out_ff(port_out_ff),
		.port_oe_n_ff(port_oe_n_ff), .reset_standby_pin(rst_pin),
		.external_fetch_select(ext_sel), .addr_latch_burn_pin_in(ale_pin),
		.addr_latch_burn_pin_out_ff(ale_out), .addr_latch_burn_pin_oe_n_ff(ale_oe_n),
		.program_fetch_strobe_n_ff(strobe_n), .program_fetch_strobe_oe_n_ff(strobe_oe_n));
	ext_mem_model mem (.clk(clk), .ale(ale_pin), .fetch_n(fetch_pin), .pin(pins),
		.p0_drv(m_drv), .p0_en(m_en));

	function automatic logic [7:0] exp_code(input logic [15:0] a);
		return a[7:0] ^ a[15:8] ^ 8'hA5;
	endfunction
	task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	// one transfer: hold until taken, then wait for the byte under a bound
	task automatic do_req(input row_s w, output logic [7:0] got);
		int i;
		@(posedge clk) req <= '{1'b1, w.a, w.d, w.w, w.wr, w.a, w.v};
		i = 0;
		do begin @(negedge clk); i++; end while (req_taken_ff !== 1'b1 && i < 40);
		@(posedge clk) req <= '0;
		i = 0;
		while (code_valid_ff !== 1'b1 && data_valid_ff !== 1'b1 && i < 20) begin
			@(negedge clk);
			i++;
		end
		got = (i >= 20) ? 8'hXX : (w.d ? data_rdata_ff : code_byte_ff);
		repeat (12) @(posedge clk);
	endtask
	task automatic summarize();
		$display("checks %0d, mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// watchdog, well past the roughly 400 clocks the tests need
	initial begin
		repeat (6000) @(posedge clk);
		n_fail++;
		$display("unexpected run length: expected end, seen timeout");
		summarize();
	end
	initial begin
		int k;
		logic [7:0] got;
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		repeat (8) @(posedge clk);
		for (k = 0; k < 6; k++) begin
			do_req(rows[k], got);
			if (!rows[k].wr) chk8("bus byte", rows[k].d ? rows[k].v : exp_code(rows[k].a), got);
			$display("row %0d done", k);
		end
		// short reset pulse must not reset the core
		rst_pin <= 1'b1;
		repeat (10) @(posedge clk) rst_pin <= 1'b0;
		repeat (6) @(posedge clk);
		chk8("short reset", 8'h00, {7'h0, core_reset_ff});
		$display("reset pulse done");
		// burn one byte at 234h, then read it back in verify mode
		ext_drv <= {8'hFF, 8'h82, 8'h34, 8'h96};
		rst_pin <= 1'b1;
		repeat (40) @(posedge clk);
		chk8("held reset", 8'h01, {7'h0, core_reset_ff & (&port_oe_n_ff)});
		chk8("latch pin released", 8'h01, {7'h0, ale_oe_n});
		burn_pulse_input_n <= 1'b0;
		repeat (6) @(posedge clk) burn_pulse_input_n <= 1'b1;
		repeat (6) @(posedge clk) ext_drv <= {8'hFF, 8'h02, 8'h34, 8'hFF};
		repeat (10) @(posedge clk);
		chk8("verify byte", 8'h96, pins.p0);
		rst_pin <= 1'b0;
		ext_drv <= '1;
		ext_sel <= 1'b1;
		repeat (40) @(posedge clk);
		k = n_strobe;
		do_req('{1'b0, 1'b0, 1'b0, 16'h0234, 8'h00}, got);
		chk8("on-chip byte", 8'h96, got);
		chk8("on-chip strobes", 8'h00, 8'(n_strobe - k));
		do_req('{1'b0, 1'b0, 1'b0, 16'h1000, 8'h00}, got);
		chk8("above limit byte", exp_code(16'h1000), got);
		chk8("above limit strobes", 8'h01, {7'h0, n_strobe > k});
		$display("programming and fetch select done");
		// port pins: open drain, pull-ups and alternate functions
		latch <= {8'hFF, 8'h5A, 8'h0F, 8'h0F};
		ext_drv <= {8'hE3, 8'hFF, 8'hAF, 8'hFF};
		txd_bit <= 1'b0;
		ram_we <= 1'b1;
		ram_addr <= 7'h7F;
		ram_wdata <= 8'h5E;
		@(posedge clk) ram_we <= 1'b0;
		repeat (8) @(posedge clk);
		chk8("open drain enables", 8'h0F, port_oe_n_ff.p0);
		chk8("quasi port read", 8'h0F, pin_in_ff.p1);
		chk8("alternate pins", 8'hE1, pin_in_ff.p3);
		chk8("data memory", 8'h5E, ram_rdata_ff);
		$display("port pins done");
		summarize();
	end
endmodule
